// >>> hdl/pot_pkg.sv
package pot_pkg;
    localparam int NUM_CHAN = 4;
    localparam int NUM_ROW = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [2:0] ADDR_CTRL = 3'h7;
    localparam logic [2:0] ADDR_RESET = 3'h0;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    localparam int CTRL_NV_BIT = 0;
    localparam int CTRL_ROW_LSB = 1;
    localparam logic [7:0] UNUSED_READ = 8'h00;
    localparam logic [7:0] STORED_RESET = 8'h00;
    localparam logic [7:0] WIPER_RESET = 8'h00;
    localparam logic [3:0] BIT_DONE = 4'h8;

    typedef struct packed {
        logic [1:0] chan;
        logic [7:0] value;
    } pot_upd_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0011,
        ST_REGA = 4'b0010,
        ST_REGA_ACK = 4'b0110,
        ST_WDATA = 4'b0111,
        ST_WDATA_ACK = 4'b0101,
        ST_RDATA = 4'b0100,
        ST_RACK = 4'b1100
    } pot_state_type;
endpackage : pot_pkg

// >>> hdl/pot_register_move_read.sv
`timescale 1ns/10ps
module pot_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        else if (pop && !push)
            cnt_d = (AW+1)'(cnt_q - 1'b1);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end
endmodule : pot_fifo

module pot_register_move_read #(
    parameter logic [6:0] DEV_ADDR = 7'h28
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic store_we,
    input wire logic [1:0] store_row,
    input wire logic [1:0] store_chan,
    input wire logic [7:0] store_data,
    output logic [pot_pkg::NUM_CHAN-1:0][7:0] wiper_position_reg,
    output logic [2:0] select_control_reg,
    output logic upd_valid,
    input wire logic upd_ready,
    output pot_pkg::pot_upd_type upd_data
);
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    pot_pkg::pot_state_type st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, tx_q, tx_d, pick_v;
    logic rw_q, rw_d, ack_q, ack_d, drive_q, drive_d;
    logic [2:0] ptr_q, ptr_d, ctrl_q, ctrl_d;
    logic [7:0] stored_q [pot_pkg::NUM_ROW][pot_pkg::NUM_CHAN];
    logic [pot_pkg::NUM_CHAN-1:0][7:0] wip_q, wip_d;
    logic [2:0] mv_q, mv_d;
    logic [1:0] move_row;
    logic move_go, hold_q, hold_d, ov_q, ov_d;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    pot_pkg::pot_upd_type f_in_data, f_out_data, od_q, od_d;
    assign scl_rise = scl_s_q && !scl_p_q;
    assign scl_fall = !scl_s_q && scl_p_q;
    assign start_seen = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    assign stop_seen = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
    // Two-stage synchronisers; third stage only for edge detection
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3f;
        else
            {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <=
                {scl_in, scl_m_q, scl_s_q, sda_in, sda_m_q, sda_s_q};
    end

    always_comb
    begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        tx_d = tx_q;
        rw_d = rw_q;
        ack_d = ack_q;
        drive_d = drive_q;
        ptr_d = ptr_q;
        ctrl_d = ctrl_q;
        move_go = 1'b0;
        move_row = ctrl_q[2:1];
        pick_v = pick_byte(ptr_q);
        if (start_seen)
        begin
            st_d = pot_pkg::ST_ADDR;
            bit_d = '0;
            drive_d = 1'b0;
        end
        else if (stop_seen)
        begin
            st_d = pot_pkg::ST_IDLE;
            drive_d = 1'b0;
        end
        else if (scl_rise)
        begin
            sh_d = {sh_q[6:0], sda_s_q};
            bit_d = 4'(bit_q + 1'b1);
            if (st_q == pot_pkg::ST_RACK)
                ack_d = !sda_s_q;
        end
        else if (scl_fall)
        begin
            case (st_q)
                pot_pkg::ST_ADDR:
                    if (bit_q == pot_pkg::BIT_DONE)
                    begin
                        if (sh_q[7:1] == DEV_ADDR)
                        begin
                            st_d = pot_pkg::ST_ADDR_ACK;
                            rw_d = sh_q[0];
                            drive_d = 1'b1;
                        end
                        else
                            st_d = pot_pkg::ST_IDLE;
                    end
                pot_pkg::ST_ADDR_ACK:
                begin
                    bit_d = '0;
                    if (rw_q)
                    begin
                        // One-byte header reads from the current pointer
                        st_d = pot_pkg::ST_RDATA;
                        tx_d = pick_v;
                        move_go = (ptr_q[2] == 1'b0) && ctrl_q[pot_pkg::CTRL_NV_BIT];
                        drive_d = !pick_v[7];
                    end
                    else
                    begin
                        st_d = pot_pkg::ST_REGA;
                        drive_d = 1'b0;
                    end
                end
                pot_pkg::ST_REGA:
                    if (bit_q == pot_pkg::BIT_DONE)
                    begin
                        st_d = pot_pkg::ST_REGA_ACK;
                        ptr_d = sh_q[2:0];
                        drive_d = 1'b1;
                    end
                pot_pkg::ST_REGA_ACK, pot_pkg::ST_WDATA_ACK:
                begin
                    st_d = pot_pkg::ST_WDATA;
                    bit_d = '0;
                    drive_d = 1'b0;
                end
                pot_pkg::ST_WDATA:
                    if (bit_q == pot_pkg::BIT_DONE)
                    begin
                        // Only the control register is writable here
                        st_d = pot_pkg::ST_WDATA_ACK;
                        drive_d = 1'b1;
                        if (ptr_q == pot_pkg::ADDR_CTRL)
                        begin
                            ctrl_d = sh_q[2:0];
                            move_go = sh_q[pot_pkg::CTRL_NV_BIT];
                            move_row = sh_q[2:1]; // Row just written, not the old one
                        end
                    end
                pot_pkg::ST_RDATA:
                    if (bit_q == pot_pkg::BIT_DONE)
                    begin
                        st_d = pot_pkg::ST_RACK;
                        drive_d = 1'b0;
                        if (ptr_q[2] == 1'b0)
                            ptr_d = {1'b0, 2'(ptr_q[1:0] + 1'b1)};
                    end
                    else
                    begin
                        tx_d = {tx_q[6:0], 1'b0};
                        drive_d = !tx_q[6];
                    end
                pot_pkg::ST_RACK:
                begin
                    bit_d = '0;
                    if (ack_q)
                    begin
                        st_d = pot_pkg::ST_RDATA;
                        tx_d = pick_v;
                        move_go = (ptr_q[2] == 1'b0) && ctrl_q[pot_pkg::CTRL_NV_BIT];
                        drive_d = !pick_v[7];
                    end
                    else
                    begin
                        st_d = pot_pkg::ST_IDLE;
                        drive_d = 1'b0;
                    end
                end
                default:
                    drive_d = 1'b0;
            endcase
        end
    end

    // Byte returned for a register address
    function automatic logic [7:0] pick_byte(input logic [2:0] a);
        if (a == pot_pkg::ADDR_CTRL)
            return {5'h00, ctrl_q};
        if (a[2])
            return pot_pkg::UNUSED_READ;
        if (ctrl_q[pot_pkg::CTRL_NV_BIT])
            return stored_q[ctrl_q[2:1]][a[1:0]];
        return wip_q[a[1:0]];
    endfunction : pick_byte

    // Move loads wipers at once and queues four update records;
    // SCL is held low until the queue has taken them all
    always_comb
    begin
        wip_d = wip_q;
        mv_d = mv_q;
        f_in_valid = (mv_q != 3'h0);
        f_in_data.chan = 2'(3'h4 - mv_q);
        f_in_data.value = wip_q[2'(3'h4 - mv_q)];
        if (f_in_valid && f_in_ready)
            mv_d = 3'(mv_q - 1'b1);
        if (move_go)
        begin
            for (int c = 0; c < pot_pkg::NUM_CHAN; c++)
                wip_d[c] = stored_q[move_row][c];
            mv_d = 3'h4;
        end
        hold_d = (mv_d != 3'h0);
        f_out_ready = !ov_q || upd_ready;
        ov_d = f_out_ready ? f_out_valid : ov_q;
        od_d = f_out_ready ? f_out_data : od_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_q <= pot_pkg::ST_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            tx_q <= '0;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            drive_q <= 1'b0;
            ptr_q <= pot_pkg::ADDR_RESET;
            ctrl_q <= pot_pkg::CTRL_RESET;
            wip_q <= '{default: pot_pkg::WIPER_RESET};
            mv_q <= '0;
            hold_q <= 1'b0;
            ov_q <= 1'b0;
            od_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            rw_q <= rw_d;
            ack_q <= ack_d;
            drive_q <= drive_d;
            ptr_q <= ptr_d;
            ctrl_q <= ctrl_d;
            wip_q <= wip_d;
            mv_q <= mv_d;
            hold_q <= hold_d;
            ov_q <= ov_d;
            od_q <= od_d;
        end
    end

    // Stored settings loaded from the user side; no nonvolatile cycle here
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            stored_q <= '{default: '{default: pot_pkg::STORED_RESET}};
        else if (store_we)
            stored_q[store_row][store_chan] <= store_data;
    end

    pot_fifo #(.WIDTH($bits(pot_pkg::pot_upd_type)), .DEPTH(pot_pkg::FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe = drive_q;
    assign scl_oe = hold_q;
    assign wiper_position_reg = wip_q;
    assign select_control_reg = ctrl_q;
    assign upd_valid = ov_q;
    assign upd_data = od_q;
endmodule : pot_register_move_read

// >>> dv/pot_register_move_read_props.sv
`timescale 1ns/10ps
module pot_register_move_read_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic store_we,
    input wire logic [1:0] store_row,
    input wire logic [1:0] store_chan,
    input wire logic [7:0] store_data,
    input wire logic [pot_pkg::NUM_CHAN-1:0][7:0] wiper_position_reg,
    input wire logic [2:0] select_control_reg,
    input wire logic upd_valid,
    input wire logic upd_ready,
    input wire pot_pkg::pot_upd_type upd_data
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0) else $error("sda_out not low");
    AST_SCL_OPEN_DRAIN: assert property (scl_out == 1'b0) else $error("scl_out not low");
    AST_RESET_STATE: assert property (disable iff (1'b0) !rst_n |=>
        !sda_oe && !upd_valid && select_control_reg == 3'h1) else $error("bad reset state");
    AST_SDA_DRIVE_ON_LOW: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("sda_oe rose while scl high");
    AST_SDA_STABLE_HIGH: assert property ($past(rst_n) && scl_in && $past(scl_in) && $past(scl_in, 3)
        |-> $stable(sda_oe)) else $error("sda_oe moved in scl high");
    AST_UPD_HOLD: assert property (upd_valid && !upd_ready |=> upd_valid && $stable(upd_data))
        else $error("update record dropped");
    AST_UPD_CHAN_ORDER: assert property (upd_valid && upd_ready ##1 upd_valid
        |-> upd_data.chan == $past(upd_data.chan) + 2'h1) else $error("record channel order");
    AST_WIPER_STRETCH: assert property ($past(rst_n) && $changed(wiper_position_reg) |-> scl_oe)
        else $error("wiper moved without stretch");
    AST_STRETCH_FEEDS: assert property ($rose(scl_oe) |-> ##[1:8] upd_valid)
        else $error("no record after stretch");

    cover property (upd_valid && upd_ready);
    cover property ($rose(scl_oe));
    cover property ($rose(sda_oe));
endmodule : pot_register_move_read_props

bind pot_register_move_read pot_register_move_read_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .store_we(store_we), .store_row(store_row), .store_chan(store_chan),
    .store_data(store_data), .wiper_position_reg(wiper_position_reg),
    .select_control_reg(select_control_reg), .upd_valid(upd_valid), .upd_ready(upd_ready),
    .upd_data(upd_data));

// >>> dv/pot_i2c_master.sv
`timescale 1ns/10ps
module pot_i2c_master (
    input wire logic sys_clk,
    input wire logic scl_oe,
    input wire logic sda_oe,
    output logic scl_line,
    output logic sda_line
);
    logic m_scl = 1'b1;
    logic m_sda = 1'b1;
    // Pulled-up wires: low while either party pulls
    assign scl_line = m_scl & !scl_oe;
    assign sda_line = m_sda & !sda_oe;

    task automatic hc;
        repeat (8) @(posedge sys_clk);
    endtask : hc

    task automatic scl_hi;
        int n;
        n = 0;
        m_scl <= 1'b1;
        @(posedge sys_clk);
        // Device stretches while its update queue fills
        while (!scl_line && n < 4000)
        begin
            @(posedge sys_clk);
            n++;
        end
        hc();
    endtask : scl_hi

    task automatic start;
        m_sda <= 1'b1;
        hc();
        scl_hi();
        m_sda <= 1'b0;
        hc();
        m_scl <= 1'b0;
        hc();
    endtask : start

    task automatic stop;
        m_sda <= 1'b0;
        hc();
        scl_hi();
        m_sda <= 1'b1;
        hc();
    endtask : stop

    task automatic xbit(input logic b, output logic r);
        m_sda <= b;
        hc();
        scl_hi();
        r = sda_line;
        m_scl <= 1'b0;
        hc();
    endtask : xbit

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(d[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask : wbyte

    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            xbit(1'b1, r);
            d = {d[6:0], r};
        end
        xbit(!ack, r);
    endtask : rbyte
endmodule : pot_i2c_master

// >>> dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam logic [6:0] DEV = 7'h28;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic store_we = 1'b0;
    logic [1:0] store_row = 2'h0;
    logic [1:0] store_chan = 2'h0;
    logic [7:0] store_data = 8'h00;
    logic upd_ready = 1'b0;
    logic scl_line, sda_line, scl_oe, sda_oe, upd_valid;
    logic [pot_pkg::NUM_CHAN-1:0][7:0] wiper_position_reg;
    logic [2:0] select_control_reg;
    pot_pkg::pot_upd_type upd_data;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] st [4][4];
    logic [7:0] wp [4] = '{default: 8'h00};
    logic [2:0] ctrl = 3'h1;
    int ptr = 0;
    logic [9:0] q [$];
    logic [9:0] gq [$];

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    pot_register_move_read #(.DEV_ADDR(DEV)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_line),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .store_we(store_we),
        .store_row(store_row), .store_chan(store_chan), .store_data(store_data),
        .wiper_position_reg(wiper_position_reg), .select_control_reg(select_control_reg),
        .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_data(upd_data));
    pot_i2c_master u_m (.sys_clk(sys_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line),
        .sda_line(sda_line));

    task stop_test;
        $display("errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function logic [7:0] exp_byte;
        if (ptr == 7)
            return {5'h00, ctrl};
        if (ptr > 3)
            return 8'h00;
        return ctrl[0] ? st[ctrl[2:1]][ptr] : wp[ptr];
    endfunction : exp_byte

    task move;
        for (int c = 0; c < 4; c++)
        begin
            wp[c] = st[ctrl[2:1]][c];
            q.push_back({c[1:0], wp[c]});
        end
    endtask : move

    task chk_wp;
        for (int c = 0; c < 4; c++)
            chk(wiper_position_reg[c], wp[c]);
    endtask : chk_wp

    // Negative address means a one-byte header from the current pointer
    task rd(input int a, input int n);
        logic ack;
        logic [7:0] d;
        u_m.start();
        if (a >= 0)
        begin
            u_m.wbyte({DEV, 1'b0}, ack);
            chk(ack, 1);
            u_m.wbyte(a[7:0], ack);
            chk(ack, 1);
            ptr = a;
            u_m.start();
        end
        u_m.wbyte({DEV, 1'b1}, ack);
        chk(ack, 1);
        for (int i = 0; i < n; i++)
        begin
            u_m.rbyte(i < n - 1, d);
            chk(d, exp_byte());
            if (ptr < 4)
            begin
                if (ctrl[0])
                    move();
                ptr = (ptr + 1) % 4;
            end
        end
        chk(sda_oe, 0);
        u_m.stop();
        chk_wp();
    endtask : rd

    task wr7(input logic [2:0] c);
        logic ack;
        u_m.start();
        u_m.wbyte({DEV, 1'b0}, ack);
        chk(ack, 1);
        u_m.wbyte(8'h07, ack);
        chk(ack, 1);
        u_m.wbyte({5'h00, c}, ack);
        chk(ack, 1);
        u_m.stop();
        ctrl = c;
        ptr = 7;
        if (c[0])
            move();
        chk(select_control_reg, c);
        chk_wp();
    endtask : wr7

    always @(posedge sys_clk)
    begin
        upd_ready <= 1'($urandom % 2);
        if (upd_valid === 1'b1 && upd_ready === 1'b1)
            gq.push_back(upd_data);
        cycles++;
        if (cycles == 80000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        logic ack;
        void'($urandom(32'h0734));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk(select_control_reg, 3'h1);
        chk_wp();
        for (int r = 0; r < 4; r++)
            for (int c = 0; c < 4; c++)
            begin
                @(posedge sys_clk);
                st[r][c] = 8'($urandom);
                store_we <= 1'b1;
                store_row <= r[1:0];
                store_chan <= c[1:0];
                store_data <= st[r][c];
            end
        @(posedge sys_clk);
        store_we <= 1'b0;
        rd(-1, 2);
        rd(2, 5);
        rd(-1, 2);
        wr7(3'h0);
        rd(1, 4);
        rd(7, 2);
        rd(5, 1);
        for (int k = 0; k < 6; k++)
        begin
            wr7(3'($urandom));
            rd($urandom % 8, 1 + $urandom % 6);
        end
        // Foreign target address must be left unanswered
        u_m.start();
        u_m.wbyte({DEV ^ 7'h01, 1'b0}, ack);
        chk(ack, 0);
        u_m.stop();
        for (int i = 0; i < 2000 && gq.size() < q.size(); i++)
            @(posedge sys_clk);
        chk(10'(gq.size()), 10'(q.size()));
        foreach (gq[i])
            chk(gq[i], q[i]);
        stop_test();
    end
endmodule : tb_top
